// file: etx_pkg.sv
package etx_pkg;
  // client beat geometry, 100G variant
  localparam int BEAT_BITS = 512;
  localparam int EMPTY_BITS = 6;
  localparam int CORE_WORDS = 5;
  localparam int CLIENT_WORDS = 8;

  // line codes and frame bytes
  localparam logic [7:0] START_CODE = 8'hfb;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hd5;
  localparam logic [7:0] IDLE_CODE = 8'h07;
  localparam logic [7:0] TERM_CODE = 8'hfd;
  localparam logic [7:0] ERR_CODE = 8'hfe;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // crc
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_PRESET = 32'hffffffff;

  // frame byte positions and sizes
  localparam logic [13:0] MIN_FRAME = 14'h0040;
  localparam logic [13:0] FCS_BYTES = 14'h0004;
  localparam logic [13:0] PAD_FLOOR = 14'h0008;
  localparam logic [13:0] SA_FIRST = 14'h0006;
  localparam logic [13:0] SA_LAST = 14'h000b;
  localparam logic [13:0] LT_HI = 14'h000c;
  localparam logic [13:0] LT_LO = 14'h000d;
  localparam logic [15:0] TYPE_MIN = 16'h0600;
  localparam logic [2:0] PRE_LAST = 3'h7;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam logic [4:0] IPG_BYTES = 5'h0c;

  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_SA_CTRL = 10'h0c2;
  localparam logic [9:0] IDX_SA_LO = 10'h0c3;
  localparam logic [9:0] IDX_SA_HI = 10'h0c4;
  localparam logic [9:0] IDX_FCS_CFG = 10'h124;
  localparam logic [9:0] IDX_PASS_CFG = 10'h125;
  localparam logic [9:0] IDX_DEL_PERIOD = 10'h126;
  localparam logic [9:0] IDX_DEL_ENABLE = 10'h127;
  localparam logic [9:0] IDX_STATUS = 10'h128;

  // field positions
  localparam int SA_CTRL_BIT = 31;
  localparam int PASS_BIT = 1;
  localparam int FCS_BIT = 0;
  localparam int DEL_EN_BIT = 0;

  // reset values
  localparam logic [15:0] DEL_PERIOD_RST = 16'h4000;
  localparam logic DEL_EN_RST = 1'b1;
  localparam logic FCS_EN_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_DATA, ST_PAD, ST_FCS, ST_TERM
  } etx_state_t;

  typedef struct packed {
    logic [BEAT_BITS-1:0] data;
    logic [EMPTY_BITS-1:0] empty;
    logic sop;
    logic eop;
    logic err;
  } etx_beat_t;

  typedef struct packed {
    logic valid;
    logic ctrl;
    logic [7:0] data;
  } etx_line_t;
endpackage

// file: etx_frame_builder.sv
`timescale 1ns/100ps
// Summary of operation
// - every frame gets eight preamble bytes opening with start code fb.
// - pass-through bit 1 at 0x125 takes preamble and sfd from client data.
// - pass-through drops client first byte, sends start code, forwards next seven.
// - address control bit 31 replaces source address with register value.
// - length/type passes unchanged; 0x600 and above means type.
// - frames over eight and under 64 bytes padded with zeros to 64.
// - crc covers addresses, length/type, data, pad; inserted as fcs.
// - crc generator polynomial is the standard 32-bit ethernet one.
// - crc sent most significant coefficient first.
// - fcs config bit 0 enables insertion; enabled after reset.
// - deficit idle counter keeps gap at least twelve bytes, eleven when a removal credit is spent.
// - one idle byte removed per programmed period, default 16384.
// - client bus is 512 bits wide for this variant.
// - the wide client beat replaces the narrow internal word path.
// - client is source, mac is sink; sop/eop delimit, valid qualifies.
// - a beat moves in the cycle valid and ready are both high.
// - error on end beat corrupts the sent frame.
module etx_frame_builder (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // client stream
  input wire logic tx_valid,
  input wire etx_pkg::etx_beat_t tx_beat,
  output logic tx_ready,
  // line byte stream
  output etx_pkg::etx_line_t line_out
);

  // crc over one byte, msb of the byte first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[31] ^ b[i];
      r = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ etx_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  // register state
  logic sa_rep_q, sa_rep_d, pass_q, pass_d, fcs_en_q, fcs_en_d, del_en_q, del_en_d;
  logic [15:0] period_q, period_d, sa_hi_q, sa_hi_d;
  logic [31:0] sa_lo_q, sa_lo_d, prdata_q, prdata_d;
  // datapath state
  etx_pkg::etx_state_t st_q, st_d;
  etx_pkg::etx_beat_t beat_q, beat_d;
  etx_pkg::etx_line_t out_q, out_d;
  logic have_q, have_d, errf_q, errf_d, credit_q, credit_d;
  logic [5:0] ptr_q, ptr_d;
  logic [2:0] pre_q, pre_d;
  logic [1:0] fidx_q, fidx_d;
  logic [13:0] fcnt_q, fcnt_d;
  logic [4:0] gap_q, gap_d;
  logic [31:0] crc_q, crc_d;
  logic [15:0] lt_q, lt_d, dcnt_q, dcnt_d;
  logic [7:0] frames_q, frames_d;
  // datapath helpers
  logic step, pop, discard, last, release_b, take, hit, wr, fin, earn;
  logic [5:0] last_idx;
  logic [7:0] cur, b;
  logic [13:0] target;
  logic [47:0] sa_sh;
  logic [31:0] fcs_sh;
  logic [9:0] idx;

  // apb decode, zero wait states
  assign idx = paddr[11:2];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;
  assign wr = psel & penable & pwrite & hit;
  assign line_out = out_q;

  // register next values and read mux
  always_comb begin
    sa_rep_d = sa_rep_q;
    pass_d = pass_q;
    fcs_en_d = fcs_en_q;
    del_en_d = del_en_q;
    period_d = period_q;
    sa_lo_d = sa_lo_q;
    sa_hi_d = sa_hi_q;
    prdata_d = prdata_q;
    hit = 1'b1;
    unique case (idx)
      etx_pkg::IDX_SA_CTRL: prdata_d = {sa_rep_q, 31'h0};
      etx_pkg::IDX_SA_LO: prdata_d = sa_lo_q;
      etx_pkg::IDX_SA_HI: prdata_d = {16'h0, sa_hi_q};
      etx_pkg::IDX_FCS_CFG: prdata_d = {31'h0, fcs_en_q};
      etx_pkg::IDX_PASS_CFG: prdata_d = {30'h0, pass_q, 1'b0};
      etx_pkg::IDX_DEL_PERIOD: prdata_d = {16'h0, period_q};
      etx_pkg::IDX_DEL_ENABLE: prdata_d = {31'h0, del_en_q};
      etx_pkg::IDX_STATUS: begin
        prdata_d = {frames_q, 7'h0, (lt_q >= etx_pkg::TYPE_MIN), lt_q};
      end
      default: begin
        prdata_d = 32'h0;
        hit = 1'b0;
      end
    endcase
    if (!(psel & ~penable)) begin
      prdata_d = prdata_q; // read data latched in the setup cycle
    end
    if (wr) begin
      unique case (idx)
        etx_pkg::IDX_SA_CTRL: sa_rep_d = pwdata[etx_pkg::SA_CTRL_BIT];
        etx_pkg::IDX_SA_LO: sa_lo_d = pwdata;
        etx_pkg::IDX_SA_HI: sa_hi_d = pwdata[15:0];
        etx_pkg::IDX_FCS_CFG: fcs_en_d = pwdata[etx_pkg::FCS_BIT];
        etx_pkg::IDX_PASS_CFG: pass_d = pwdata[etx_pkg::PASS_BIT];
        etx_pkg::IDX_DEL_PERIOD: period_d = pwdata[15:0];
        etx_pkg::IDX_DEL_ENABLE: del_en_d = pwdata[etx_pkg::DEL_EN_BIT];
        default: sa_rep_d = sa_rep_q;
      endcase
    end
  end

  // register flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sa_rep_q <= 1'b0;
      pass_q <= 1'b0;
      fcs_en_q <= etx_pkg::FCS_EN_RST;
      del_en_q <= etx_pkg::DEL_EN_RST;
      period_q <= etx_pkg::DEL_PERIOD_RST;
      sa_lo_q <= 32'h0;
      sa_hi_q <= 16'h0;
      prdata_q <= 32'h0;
    end else begin
      sa_rep_q <= sa_rep_d;
      pass_q <= pass_d;
      fcs_en_q <= fcs_en_d;
      del_en_q <= del_en_d;
      period_q <= period_d;
      sa_lo_q <= sa_lo_d;
      sa_hi_q <= sa_hi_d;
      prdata_q <= prdata_d;
    end
  end

  // beat holding and byte pick, top lane first
  assign cur = beat_q.data[{~ptr_q, 3'h0} +: 8];
  assign last_idx = beat_q.eop ? (6'h3f - beat_q.empty) : 6'h3f;
  assign last = (ptr_q == last_idx);
  assign release_b = have_q & (discard | (pop & last));
  assign tx_ready = ~have_q | release_b;
  assign take = tx_valid & tx_ready;
  assign target = fcs_en_q ? (etx_pkg::MIN_FRAME - etx_pkg::FCS_BYTES) : etx_pkg::MIN_FRAME;
  assign sa_sh = {sa_hi_q, sa_lo_q} << {fcnt_q[2:0] - 3'h6, 3'h0};
  assign fcs_sh = (~crc_q ^ {31'h0, errf_q}) << {fidx_q, 3'h0};

  // frame sequencer next state
  always_comb begin
    st_d = st_q;
    pre_d = pre_q;
    fidx_d = fidx_q;
    fcnt_d = fcnt_q;
    gap_d = gap_q;
    crc_d = crc_q;
    errf_d = errf_q;
    lt_d = lt_q;
    frames_d = frames_q;
    out_d = '{valid: 1'b1, ctrl: 1'b1, data: etx_pkg::IDLE_CODE};
    step = 1'b1;
    pop = 1'b0;
    discard = 1'b0;
    fin = 1'b0;
    b = cur;
    unique case (st_q)
      etx_pkg::ST_IDLE: begin
        if (gap_q != 5'h0) begin
          gap_d = gap_q - 5'h1;
        end else if (have_q && beat_q.sop) begin
          st_d = etx_pkg::ST_PRE;
          pre_d = 3'h0;
        end else if (have_q) begin
          discard = 1'b1; // beat outside a packet is dropped
        end
      end
      etx_pkg::ST_PRE: begin
        step = pass_q ? have_q : 1'b1;
        pop = pass_q & have_q;
        crc_d = etx_pkg::CRC_PRESET;
        out_d.ctrl = (pre_q == 3'h0);
        if (pre_q == 3'h0) begin
          out_d.data = etx_pkg::START_CODE;
        end else if (pass_q) begin
          out_d.data = cur;
        end else if (pre_q == etx_pkg::PRE_LAST) begin
          out_d.data = etx_pkg::SFD_BYTE;
        end else begin
          out_d.data = etx_pkg::PRE_BYTE;
        end
        if (step) begin
          pre_d = pre_q + 3'h1;
          if (pre_q == etx_pkg::PRE_LAST) begin
            st_d = etx_pkg::ST_DATA;
            fcnt_d = 14'h0;
          end
        end
      end
      etx_pkg::ST_DATA: begin
        step = have_q;
        pop = have_q;
        if (sa_rep_q && fcnt_q >= etx_pkg::SA_FIRST && fcnt_q <= etx_pkg::SA_LAST) begin
          b = sa_sh[47:40];
        end
        out_d.ctrl = 1'b0;
        out_d.data = b;
        if (step) begin
          crc_d = crc_byte(crc_q, b);
          fcnt_d = fcnt_q + 14'h1;
          if (fcnt_q == etx_pkg::LT_HI) lt_d = {b, lt_q[7:0]};
          if (fcnt_q == etx_pkg::LT_LO) lt_d = {lt_q[15:8], b};
          if (last && beat_q.eop) begin
            errf_d = beat_q.err;
            fidx_d = 2'h0;
            if (fcnt_d > etx_pkg::PAD_FLOOR && fcnt_d < target) begin
              st_d = etx_pkg::ST_PAD;
            end else if (fcs_en_q) begin
              st_d = etx_pkg::ST_FCS;
            end else begin
              st_d = etx_pkg::ST_TERM;
            end
          end
        end
      end
      etx_pkg::ST_PAD: begin
        out_d.ctrl = 1'b0;
        out_d.data = etx_pkg::PAD_BYTE;
        crc_d = crc_byte(crc_q, etx_pkg::PAD_BYTE);
        fcnt_d = fcnt_q + 14'h1;
        if (fcnt_d == target) begin
          st_d = fcs_en_q ? etx_pkg::ST_FCS : etx_pkg::ST_TERM;
        end
      end
      etx_pkg::ST_FCS: begin
        out_d.ctrl = 1'b0;
        out_d.data = fcs_sh[31:24];
        fidx_d = fidx_q + 2'h1;
        if (fidx_q == etx_pkg::FCS_LAST) st_d = etx_pkg::ST_TERM;
      end
      etx_pkg::ST_TERM: begin
        out_d.data = errf_q ? etx_pkg::ERR_CODE : etx_pkg::TERM_CODE;
        st_d = etx_pkg::ST_IDLE;
        gap_d = etx_pkg::IPG_BYTES - 5'h1 - {4'h0, credit_q};
        frames_d = frames_q + 8'h1;
        fin = 1'b1;
      end
      default: st_d = etx_pkg::ST_IDLE;
    endcase
    if (!step) begin
      out_d.valid = 1'b0; // underrun stalls rather than corrupting
    end
  end

  // beat register and idle removal counter next values
  always_comb begin
    beat_d = beat_q;
    have_d = have_q;
    ptr_d = ptr_q;
    if (take) begin
      beat_d = tx_beat;
      have_d = 1'b1;
      ptr_d = 6'h0;
    end else if (release_b) begin
      have_d = 1'b0;
    end else if (pop) begin
      ptr_d = ptr_q + 6'h1;
    end
    earn = 1'b0;
    dcnt_d = dcnt_q;
    if (out_q.valid) begin
      dcnt_d = dcnt_q + 16'h1;
      if (del_en_q && period_q != 16'h0 && dcnt_q >= period_q - 16'h1) begin
        dcnt_d = 16'h0;
        earn = 1'b1;
      end
    end
    credit_d = earn | (credit_q & ~fin); // a fresh credit beats its use
  end

  // datapath flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= etx_pkg::ST_IDLE;
      beat_q <= '0;
      have_q <= 1'b0;
      ptr_q <= 6'h0;
      pre_q <= 3'h0;
      fidx_q <= 2'h0;
      fcnt_q <= 14'h0;
      gap_q <= 5'h0;
      crc_q <= etx_pkg::CRC_PRESET;
      errf_q <= 1'b0;
      lt_q <= 16'h0;
      frames_q <= 8'h0;
      out_q <= '0;
      dcnt_q <= 16'h0;
      credit_q <= 1'b0;
    end else begin
      st_q <= st_d;
      beat_q <= beat_d;
      have_q <= have_d;
      ptr_q <= ptr_d;
      pre_q <= pre_d;
      fidx_q <= fidx_d;
      fcnt_q <= fcnt_d;
      gap_q <= gap_d;
      crc_q <= crc_d;
      errf_q <= errf_d;
      lt_q <= lt_d;
      frames_q <= frames_d;
      out_q <= out_d;
      dcnt_q <= dcnt_d;
      credit_q <= credit_d;
    end
  end

  // checks on the sequencer
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_idle_run;
    ##1 (st_q == etx_pkg::ST_IDLE && out_q.ctrl) [*8];
  endsequence

  a_start_code: assert property ((st_q == etx_pkg::ST_PRE && pre_q == 3'h0) |=>
    (out_q.data == etx_pkg::START_CODE && out_q.ctrl))
    else $error("start code missing");
  a_pass_forward: assert property ((st_q == etx_pkg::ST_PRE && pass_q && pre_q != 3'h0
    && have_q) |=> (out_q.data == $past(cur) && !out_q.ctrl))
    else $error("preamble byte not forwarded");
  a_sa_swap: assert property ((st_q == etx_pkg::ST_DATA && sa_rep_q && have_q
    && fcnt_q == etx_pkg::SA_FIRST) |=> out_q.data == $past(sa_hi_q[15:8]))
    else $error("source address not replaced");
  a_pad_zero: assert property ((st_q == etx_pkg::ST_PAD) |=>
    (out_q.data == 8'h00 && !out_q.ctrl && out_q.valid))
    else $error("pad byte not zero");
  a_fcs_first: assert property ((st_q == etx_pkg::ST_FCS && fidx_q == 2'h0 && !errf_q)
    |=> out_q.data == ~($past(crc_q[31:24])))
    else $error("fcs order wrong");
  a_fcs_default: assert property ($rose(rst_n) |-> fcs_en_q)
    else $error("fcs insert off after reset");
  a_gap_min: assert property ((st_q == etx_pkg::ST_TERM) |-> s_idle_run)
    else $error("gap too short");
  a_ready_take: assert property ((tx_valid && tx_ready) |=>
    (have_q && beat_q == $past(tx_beat)))
    else $error("beat not taken");
  a_err_mark: assert property ((st_q == etx_pkg::ST_TERM && errf_q) |=>
    out_q.data == etx_pkg::ERR_CODE)
    else $error("error frame not marked");
  a_crc_preset: assert property ((st_q == etx_pkg::ST_PRE && pre_q == etx_pkg::PRE_LAST
    && step) |=> (st_q == etx_pkg::ST_DATA && crc_q == 32'hffffffff))
    else $error("crc not preset");
endmodule

// file: etx_client_src.sv
`timescale 1ns/100ps
module etx_client_src (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // stream to the mac
  output logic tx_valid,
  output etx_pkg::etx_beat_t tx_beat,
  input wire logic tx_ready
);
  logic [7:0] buf_q [0:127];

  // bus quiet until the first packet
  initial begin
    tx_valid = 1'b0;
    tx_beat = '0;
  end

  // sends reps copies of the buffered packet, beats held until taken
  task automatic send(input int n, input logic err, input int reps);
    int b, i, last;
    for (int r = 0; r < reps; r++) begin
      for (b = 0; b * 64 < n; b++) begin
        last = (b * 64 + 64 >= n);
        tx_valid <= 1'b1;
        for (i = 0; i < 64; i++)
          tx_beat.data[511 - 8 * i -: 8] <= buf_q[(b * 64 + i) % 128];
        tx_beat.sop <= (b == 0);
        tx_beat.eop <= 1'(last);
        tx_beat.err <= err & 1'(last);
        tx_beat.empty <= last ? 6'(b * 64 + 64 - n) : 6'h00;
        @(posedge mclk);
        while (tx_ready !== 1'b1) @(posedge mclk);
      end
    end
    // released bus shows the inverse of the last beat
    tx_valid <= 1'b0;
    tx_beat <= ~tx_beat;
  endtask
endmodule

// file: test_etx_frame_builder.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
    end \
  end
module test_etx_frame_builder;
  localparam logic [47:0] SA_V = 48'ha1b2c3d4e5f6;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, tx_valid, tx_ready, ps;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  etx_pkg::etx_beat_t tx_beat;
  etx_pkg::etx_line_t line_out;
  logic [8:0] got_q[$];
  logic [8:0] exp_q[$];
  int n_mismatch = 0, checked = 0, n_term = 0, gap = 0, min_gap = 99;
  int lens[7] = '{8, 9, 20, 59, 60, 64, 100};

  etx_frame_builder dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_valid(tx_valid), .tx_beat(tx_beat), .tx_ready(tx_ready),
    .line_out(line_out));
  etx_client_src src (.mclk(mclk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_beat(tx_beat),
    .tx_ready(tx_ready));

  // 50 ns clock
  always #25 mclk = ~mclk;

  // collects non-idle line bytes and measures idle runs before each start
  always @(posedge mclk) begin
    if (rst_n && line_out.valid) begin
      if (line_out.ctrl && line_out.data == etx_pkg::IDLE_CODE) begin
        gap++;
      end else begin
        if (line_out.ctrl && line_out.data == etx_pkg::START_CODE) begin
          if (gap < min_gap)
            min_gap = gap;
        end else if (line_out.ctrl) begin
          n_term++; // terminate and error codes (any control byte but idle or start) end a frame
        end
        got_q.push_back({line_out.ctrl, line_out.data});
        gap = 0;
      end
    end
  end

  function automatic logic [31:0] crc_next(logic [31:0] c, logic [7:0] b);
    for (int k = 7; k >= 0; k--)
      c = (c[31] ^ b[k]) ? ({c[30:0], 1'b0} ^ 32'h04c11db7) : {c[30:0], 1'b0};
    return c;
  endfunction

  // one apb transfer, result in rd and ps
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    ps = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // builds the expected line bytes, sends the packet, compares
  task automatic frame(input int n, input logic [15:0] lt, input bit sa, input bit pas,
                       input bit fcs, input bit err, input int reps);
    logic [7:0] p[$];
    logic [31:0] c;
    int o, t;
    o = pas ? 8 : 0;
    for (int i = 0; i < n; i++)
      p.push_back(i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'(i * 7 + 1));
    for (int i = 0; i < 8; i++)
      src.buf_q[i] = (i == 7) ? etx_pkg::SFD_BYTE : 8'(8'ha0 + i);
    foreach (p[i]) src.buf_q[o + i] = p[i];
    if (sa) for (int i = 0; i < 6; i++) p[6 + i] = SA_V[47 - 8 * i -: 8];
    while (n > 8 && p.size() < (fcs ? 60 : 64)) p.push_back(8'h00);
    c = 32'hffffffff;
    foreach (p[i]) c = crc_next(c, p[i]);
    c = ~c ^ 32'(err);
    repeat (reps) begin
      exp_q.push_back({1'b1, 8'hfb});
      for (int i = 1; i < 8; i++)
        exp_q.push_back({1'b0, pas ? src.buf_q[i] : (i == 7 ? 8'hd5 : 8'h55)});
      foreach (p[i]) exp_q.push_back({1'b0, p[i]});
      if (fcs) for (int i = 3; i >= 0; i--) exp_q.push_back({1'b0, c[8 * i +: 8]});
      exp_q.push_back({1'b1, err ? 8'hfe : 8'hfd});
    end
    t = n_term + reps;
    src.send(n + o, err, reps);
    while (n_term < t) @(posedge mclk);
    `CHK("byte count", exp_q.size(), got_q.size())
    foreach (exp_q[i])
      `CHK("line byte", exp_q[i], (i < got_q.size()) ? got_q[i] : 9'h1ff)
    exp_q.delete();
    got_q.delete();
  endtask

  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cuts a hang short
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(0, etx_pkg::IDX_FCS_CFG, 0);
    `CHK("fcs cfg reset", 32'h1, rd)
    apb(0, etx_pkg::IDX_DEL_PERIOD, 0);
    `CHK("period reset", 32'h4000, rd)
    apb(0, etx_pkg::IDX_DEL_ENABLE, 0);
    `CHK("removal reset", 32'h1, rd)
    apb(1, etx_pkg::IDX_SA_LO, SA_V[31:0]);
    apb(1, etx_pkg::IDX_SA_HI, 32'hffff0000 | SA_V[47:32]);
    apb(0, etx_pkg::IDX_SA_HI, 0);
    `CHK("sa high", {16'h0, SA_V[47:32]}, rd)
    apb(1, 10'h3ff, 32'h1234);
    `CHK("unmapped err", 1'b1, ps)
    apb(1, etx_pkg::IDX_DEL_ENABLE, 0);
    for (int k = 0; k < 7; k++) begin
      frame(lens[k], k[0] ? 16'h0600 : 16'h05ff, 0, 0, 1, 0, 1);
      apb(0, etx_pkg::IDX_STATUS, 0);
      if (lens[k] >= 14) `CHK("status", {k[0], k[0] ? 16'h0600 : 16'h05ff}, rd[16:0])
      `CHK("frame count", 8'(k + 1), rd[31:24])
    end
    min_gap = 99;
    frame(100, 16'h0800, 0, 0, 1, 0, 3);
    `CHK("gap floor", 1'b1, 1'(min_gap >= 12))
    apb(1, etx_pkg::IDX_DEL_PERIOD, 32'h40);
    apb(1, etx_pkg::IDX_DEL_ENABLE, 1);
    min_gap = 99;
    frame(100, 16'h0800, 0, 0, 1, 0, 3);
    `CHK("gap removal", 11, min_gap)
    apb(1, etx_pkg::IDX_SA_CTRL, 32'h80000000);
    frame(60, 16'h0800, 1, 0, 1, 0, 1);
    apb(1, etx_pkg::IDX_SA_CTRL, 0);
    apb(1, etx_pkg::IDX_PASS_CFG, 32'h2);
    frame(30, 16'h0010, 0, 1, 1, 0, 1);
    apb(1, etx_pkg::IDX_PASS_CFG, 0);
    frame(60, 16'h0800, 0, 0, 1, 1, 1);
    apb(1, etx_pkg::IDX_FCS_CFG, 0);
    frame(20, 16'h0006, 0, 0, 0, 0, 1);
    frame(60, 16'h0800, 0, 0, 0, 1, 1);
    conclude();
  end
endmodule
